// *** shared/ldo_pkg.sv ***
// Purpose: constants and types of the LCD dither output stage
// Assumes: one 100 MHz clock; registers over Avalon-MM
// Notes:   horizontal counts are in dot ticks, vertical in lines
package ldo_pkg;

  // Register byte offsets
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_HTIM = 5'h04;
  localparam logic [4:0] A_VTIM = 5'h08;
  localparam logic [4:0] A_AUX  = 5'h0c;
  localparam logic [4:0] A_STAT = 5'h10;

  // Control bits, msb first
  typedef struct packed {
    logic ibi;  // bias inverted
    logic ifs;  // frame sync inverted
    logic ils;  // line sync inverted
    logic clock_edge_invert;  // clock_edge_invert
    logic d16;  // pixel_depth 16, else 12
    logic m8;   // mono on eight pins
    logic col;  // colour
    logic act;  // active panel
    logic en;   // enable
  } ldo_ctrl_t;

  typedef struct packed {
    logic [7:0] hbp;
    logic [7:0] hfp;
    logic [5:0] hsw;
    logic [9:0] ppl;
  } ldo_htim_t;

  typedef struct packed {
    logic [7:0] vbp;
    logic [7:0] vfp;
    logic [5:0] vsw;
    logic [9:0] lpp;
  } ldo_vtim_t;

  typedef struct packed {
    logic [7:0] bias_lines;
    logic [7:0] div;
  } ldo_aux_t;

  localparam ldo_ctrl_t CTRL_RST = 9'h000;
  localparam ldo_htim_t HTIM_RST = 32'h0404_0d40;
  localparam ldo_vtim_t VTIM_RST = 32'h0202_04f0;
  localparam ldo_aux_t  AUX_RST  = 16'h0803;

  // Dither on-count and cycle length per code, code 0 lowest nibble
  localparam logic [63:0] DITH_NUM = 64'h1184_b635_1423_4110;
  localparam logic [63:0] DITH_DEN = 64'h1195_f959_2959_f591;
  // Frame count wraps at the common multiple of all cycle lengths
  localparam logic [6:0]  FRM_LAST = 7'h59;

  typedef enum logic [1:0] {
    LDO_H_SYNC = 2'b00,
    LDO_H_BP   = 2'b01,
    LDO_H_ACT  = 2'b10,
    LDO_H_FP   = 2'b11
  } ldo_hph_t;

  typedef struct packed {
    ldo_ctrl_t   ctrl;
    ldo_htim_t   htim;
    ldo_vtim_t   vtim;
    ldo_aux_t    aux;
    logic        wrq;
    logic [31:0] rdata;
    logic [7:0]  dcnt;
    ldo_hph_t    hph;
    logic [9:0]  hcnt;
    logic [10:0] vcnt;
    logic [9:0]  xcnt;
    logic [6:0]  fcnt;
    logic [7:0]  bcnt;
    logic        hold_v;
    logic [15:0] hold;
    logic [1:0]  comp;
    logic [3:0]  prev;
    logic [7:0]  sh;
    logic [3:0]  shn;
    logic [7:0]  q0;
    logic [7:0]  q1;
    logic [1:0]  qv;
    logic        dot;
    logic        bias;
    logic        rdy;
    logic        pclk;
    logic        ls;
    logic        fs;
    logic        bi;
    logic [15:0] pd;
  } ldo_state_t;

  localparam ldo_state_t ST_RST = '{ctrl: CTRL_RST, htim: HTIM_RST, vtim: VTIM_RST,
                                    aux: AUX_RST, wrq: 1'b1, hph: LDO_H_BP, default: '0};

endpackage : ldo_pkg

// *** hw/ldo_top.sv ***
// Purpose: dither, pack, queue and drive pixels to a passive or active panel
// Assumes: pixel stream and bus on ref_clk_in; panel timing by dot ticks
// Notes:   change mode and timing only while disabled
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module ldo_top (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output wire logic [31:0] avs_readdata_out,
  output wire logic        avs_waitrequest_out,
  input  wire logic [15:0] pix_data_in,
  input  wire logic        pix_valid_in,
  output wire logic        pix_ready_out,
  output wire logic [15:0] panel_data_out,
  output wire logic        panel_dot_clock_out,
  output wire logic        line_sync_out,
  output wire logic        frame_sync_out,
  output wire logic        bias_toggle_out
);

  ldo_pkg::ldo_state_t s;
  ldo_pkg::ldo_state_t n;
  logic                tick;
  logic                ins;
  logic                ins_bit;
  logic [3:0]          cur_code;

  // Component select: 0 red, 1 green, 2 blue (mono uses 2)
  function automatic logic [3:0] comp4(input logic [15:0] p, input logic d16,
                                       input logic [1:0] k);
    case (k)
      2'h0:    comp4 = d16 ? p[15:12] : p[11:8];
      2'h1:    comp4 = d16 ? p[10:7] : p[7:4];
      default: comp4 = d16 ? p[4:1] : p[3:0];
    endcase
  endfunction : comp4

  // On for num of every den steps of the phase sum
  function automatic logic dith(input logic [3:0] c, input logic [8:0] sum);
    logic [3:0] num;
    logic [3:0] den;
    logic [8:0] r;
    num = ldo_pkg::DITH_NUM[c*4 +: 4];
    den = ldo_pkg::DITH_DEN[c*4 +: 4];
    r = sum % {5'h00, den};
    dith = (r < {5'h00, num});
  endfunction : dith

  // Active panel word
  function automatic logic [15:0] tft(input logic [15:0] p, input logic d16);
    tft = d16 ? p : {p[11:8], p[11], p[7:4], p[7:6], p[3:0], p[3]};
  endfunction : tft

  // Whole next state
  always_comb begin : p_next
    logic [10:0] a0;
    logic [10:0] a1;
    logic [10:0] vtot;
    logic        dline;
    logic        ldone;
    logic        hstep;
    logic        wide;
    logic [9:0]  hend;
    logic [3:0]  wid;
    logic [7:0]  word;
    logic [8:0]  sum;
    a0 = 11'(s.vtim.vsw) + 11'(s.vtim.vbp) + 11'h002;
    a1 = a0 + 11'(s.vtim.lpp);
    vtot = a1 + 11'(s.vtim.vfp);
    dline = (s.vcnt >= a0) && (s.vcnt < a1);
    wide = s.ctrl.col || s.ctrl.m8;
    wid = wide ? 4'h8 : 4'h4;
    word = wide ? s.sh : {4'h0, s.sh[7:4]};
    sum = 9'(s.fcnt) + 9'(s.xcnt[5:0]) + 9'(s.vcnt[5:0]) + 9'(s.prev) + 9'(s.comp);
    cur_code = comp4(s.hold, s.ctrl.d16, s.ctrl.col ? s.comp : 2'h2);
    ins_bit = dith(cur_code, sum);
    ins = 1'b0;
    tick = (s.dcnt == s.aux.div);
    ldone = 1'b0;
    hstep = 1'b0;
    n = s;
    n.dcnt = tick ? 8'h00 : s.dcnt + 8'h01;
    n.wrq = 1'b1;
    case (s.hph)
      ldo_pkg::LDO_H_BP: hend = 10'(s.htim.hbp);
      ldo_pkg::LDO_H_FP: hend = 10'(s.htim.hfp);
      default:           hend = 10'(s.htim.hsw);
    endcase
    if (!s.ctrl.en) begin
      n.hph = ldo_pkg::LDO_H_BP;
      n.hcnt = 10'h000;
      n.vcnt = 11'h000;
      n.xcnt = 10'h000;
      n.bcnt = 8'h00;
      n.hold_v = 1'b0;
      n.comp = 2'h0;
      n.shn = 4'h0;
      n.qv = 2'b00;
      n.dot = 1'b0;
      n.bias = 1'b0;
      n.pd = 16'h0000;
    end else begin
      if (pix_valid_in && s.rdy) begin
        n.hold = pix_data_in;
        n.hold_v = 1'b1;
      end
      hstep = tick && (s.hcnt == hend);
      case (s.hph)
        ldo_pkg::LDO_H_ACT: begin
          if (!dline)
            ldone = tick && (s.hcnt == s.htim.ppl - 10'h001);
          else if (s.ctrl.act)
            ldone = tick && !s.dot && (s.xcnt == s.htim.ppl);
          else
            ldone = (s.xcnt == s.htim.ppl) && !s.hold_v && (s.shn == 4'h0)
                    && (s.qv == 2'b00) && !s.dot;
          if (ldone) begin
            n.hph = ldo_pkg::LDO_H_FP;
            n.hcnt = 10'h000;
          end else if (tick) begin
            n.hcnt = s.hcnt + 10'h001;
          end
        end
        ldo_pkg::LDO_H_BP: if (hstep) begin
          n.hph = ldo_pkg::LDO_H_ACT;
          n.xcnt = 10'h000;
        end
        ldo_pkg::LDO_H_FP: if (hstep) n.hph = ldo_pkg::LDO_H_SYNC;
        ldo_pkg::LDO_H_SYNC: if (hstep) begin
          n.hph = ldo_pkg::LDO_H_BP;
          if (s.vcnt == vtot) begin
            n.vcnt = 11'h000;
            n.fcnt = (s.fcnt == ldo_pkg::FRM_LAST) ? 7'h00 : s.fcnt + 7'h01;
          end else begin
            n.vcnt = s.vcnt + 11'h001;
          end
          // bias flips once every bias_lines + 1 lines
          if (!s.ctrl.act) begin
            n.bcnt = (s.bcnt == s.aux.bias_lines) ? 8'h00 : s.bcnt + 8'h01;
            n.bias = s.bias ^ (s.bcnt == s.aux.bias_lines);
          end
        end
        default: n.hph = ldo_pkg::LDO_H_BP;
      endcase
      if (s.hph != ldo_pkg::LDO_H_ACT)
        n.hcnt = hstep ? 10'h000 : (tick ? s.hcnt + 10'h001 : s.hcnt);
      if (s.ctrl.act) begin
        n.qv = 2'b00;
        if (tick) begin
          n.dot = !s.dot;
          if (!s.dot) begin
            n.bias = dline && (s.hph == ldo_pkg::LDO_H_ACT) && s.hold_v
                     && (s.xcnt < s.htim.ppl);
            n.pd = n.bias ? tft(s.hold, s.ctrl.d16) : 16'h0000;
            if (n.bias) begin
              n.hold_v = 1'b0;
              n.xcnt = s.xcnt + 10'h001;
            end
          end
        end
      end else begin
        // pop bottom word, raise dot clock
        if (tick) begin
          if (s.dot) begin
            n.dot = 1'b0;
          end else if (s.qv[0]) begin
            n.dot = 1'b1;
            n.pd = {8'h00, s.q0};
            n.q0 = s.q1;
            n.qv = {1'b0, s.qv[1]};
          end
        end
        n.pd = n.pd & (wide ? 16'h00ff : 16'h000f);
        if (s.shn == wid) begin
          // fill lowest empty slot; full queue stalls shifter
          if (!n.qv[1]) begin
            if (n.qv[0]) begin
              n.q1 = word;
              n.qv = 2'b11;
            end else begin
              n.q0 = word;
              n.qv = 2'b01;
            end
            n.shn = 4'h0;
          end
        end else if (s.hold_v) begin
          ins = 1'b1;
          // mono fills from sh bit 7, colour from sh bit 0
          n.sh = s.ctrl.col ? {s.sh[6:0], ins_bit} : {ins_bit, s.sh[7:1]};
          n.shn = s.shn + 4'h1;
          n.prev = cur_code;
          if (!s.ctrl.col || s.comp == 2'h2) begin
            n.hold_v = 1'b0;
            n.comp = 2'h0;
            n.xcnt = s.xcnt + 10'h001;
          end else begin
            n.comp = s.comp + 2'h1;
          end
        end
      end
    end
    n.rdy = s.ctrl.en && (n.hph == ldo_pkg::LDO_H_ACT) && dline && !n.hold_v
            && (n.xcnt < s.htim.ppl);
    // polarity applied to every control output
    n.pclk = n.dot ^ s.ctrl.clock_edge_invert;
    n.ls = (s.ctrl.en && n.hph == ldo_pkg::LDO_H_SYNC) ^ s.ctrl.ils;
    // frame sync over first lines of a frame
    n.fs = (s.ctrl.en && n.vcnt <= 11'(s.vtim.vsw)) ^ s.ctrl.ifs;
    n.bi = n.bias ^ s.ctrl.ibi;
    // Bus: answer one cycle after the request is seen
    if ((avs_read_in || avs_write_in) && s.wrq) begin
      n.wrq = 1'b0;
      case (avs_address_in)
        ldo_pkg::A_CTRL: n.rdata = 32'(s.ctrl);
        ldo_pkg::A_HTIM: n.rdata = s.htim;
        ldo_pkg::A_VTIM: n.rdata = s.vtim;
        ldo_pkg::A_AUX:  n.rdata = 32'(s.aux);
        ldo_pkg::A_STAT: n.rdata = {s.qv, s.hph, s.fcnt, s.vcnt, s.xcnt};
        default:         n.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_in && !s.wrq) begin
      case (avs_address_in)
        ldo_pkg::A_CTRL: n.ctrl = ldo_pkg::ldo_ctrl_t'(avs_writedata_in[8:0]);
        ldo_pkg::A_HTIM: n.htim = avs_writedata_in;
        ldo_pkg::A_VTIM: n.vtim = avs_writedata_in;
        ldo_pkg::A_AUX:  n.aux = ldo_pkg::ldo_aux_t'(avs_writedata_in[15:0]);
        default:         n.aux = s.aux;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      s <= ldo_pkg::ST_RST;
    else
      s <= n;
  end

  // All outputs straight from flops
  assign avs_readdata_out    = s.rdata;
  assign avs_waitrequest_out = s.wrq;
  assign pix_ready_out       = s.rdy;
  assign panel_data_out      = s.pd;
  assign panel_dot_clock_out = s.pclk;
  assign line_sync_out       = s.ls;
  assign frame_sync_out      = s.fs;
  assign bias_toggle_out     = s.bi;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_dis_data;
    !s.ctrl.en |=> panel_data_out == 16'h0000;
  endproperty
  a_dis_data: assert property (p_dis_data) else $error("data not zero while off");

  property p_dis_lvl;
    !s.ctrl.en && !avs_write_in |=> line_sync_out == s.ctrl.ils
      && frame_sync_out == s.ctrl.ifs && bias_toggle_out == s.ctrl.ibi;
  endproperty
  a_dis_lvl: assert property (p_dis_lvl) else $error("control not inactive");

  property p_mono_pins;
    s.ctrl.en && !s.ctrl.act && !s.ctrl.col && !s.ctrl.m8 && !avs_write_in
      |=> panel_data_out[15:4] == 12'h000;
  endproperty
  a_mono_pins: assert property (p_mono_pins) else $error("unused mono pins high");

  property p_fifo_order;
    s.qv != 2'b10;
  endproperty
  a_fifo_order: assert property (p_fifo_order) else $error("top slot above hole");

  property p_tft_bypass;
    s.ctrl.en && s.ctrl.act |=> s.qv == 2'b00;
  endproperty
  a_tft_bypass: assert property (p_tft_bypass) else $error("queue used on active");

  property p_dith_ends;
    ins |-> (cur_code >= 4'he) ? ins_bit : ((cur_code == 4'h0) ? !ins_bit : 1'b1);
  endproperty
  a_dith_ends: assert property (p_dith_ends) else $error("extreme code wrong");

  property p_shift_in;
    ins && !avs_write_in |=> (s.ctrl.col ? s.sh[0] : s.sh[7]) == $past(ins_bit);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not shifted in");

  property p_tft_clk;
    s.ctrl.en && s.ctrl.act && tick && !avs_write_in
      |=> panel_dot_clock_out != $past(panel_dot_clock_out);
  endproperty
  a_tft_clk: assert property (p_tft_clk) else $error("dot clock stopped");

  property p_tft_de;
    s.ctrl.en && s.ctrl.act && s.hph == ldo_pkg::LDO_H_SYNC
      |-> bias_toggle_out == s.ctrl.ibi;
  endproperty
  a_tft_de: assert property (p_tft_de) else $error("valid during sync");

  property p_rgb565;
    s.ctrl.en && s.ctrl.act && !s.ctrl.d16 && s.bias
      |-> panel_data_out[11] == panel_data_out[15]
      && panel_data_out[6:5] == panel_data_out[10:9] && panel_data_out[0] == panel_data_out[4];
  endproperty
  a_rgb565: assert property (p_rgb565) else $error("expansion not replicated");

  property p_dis_clk;
    !s.ctrl.en && !avs_write_in |=> panel_dot_clock_out == s.ctrl.clock_edge_invert;
  endproperty
  a_dis_clk: assert property (p_dis_clk) else $error("dot clock not inactive");

  property p_wide_pins;
    s.ctrl.en && !s.ctrl.act && (s.ctrl.col || s.ctrl.m8) && !avs_write_in
      |=> panel_data_out[15:8] == 8'h00;
  endproperty
  a_wide_pins: assert property (p_wide_pins) else $error("unused upper pins high");

  property p_pop_word;
    s.ctrl.en && !s.ctrl.act && tick && !s.dot && s.qv[0] && !avs_write_in
      |=> panel_data_out[7:0] == $past(s.q0)
      && panel_dot_clock_out != $past(panel_dot_clock_out);
  endproperty
  a_pop_word: assert property (p_pop_word) else $error("bottom word not driven");

  property p_bias_hold;
    s.ctrl.en && !s.ctrl.act && s.hph != ldo_pkg::LDO_H_SYNC && !avs_write_in
      |=> $stable(s.bias);
  endproperty
  a_bias_hold: assert property (p_bias_hold) else $error("bias moved off line sync");

  property p_bias_flip;
    s.ctrl.en && !s.ctrl.act && s.hph == ldo_pkg::LDO_H_SYNC && tick
      && s.hcnt == 10'(s.htim.hsw) && s.bcnt == s.aux.bias_lines
      |=> s.bias != $past(s.bias);
  endproperty
  a_bias_flip: assert property (p_bias_flip) else $error("bias did not toggle");

  property p_ls_level;
    s.ctrl.en && !avs_write_in
      |=> line_sync_out == ((s.hph == ldo_pkg::LDO_H_SYNC) ^ s.ctrl.ils);
  endproperty
  a_ls_level: assert property (p_ls_level) else $error("line sync off its region");

  property p_fs_level;
    s.ctrl.en && !avs_write_in
      |=> frame_sync_out == ((s.vcnt <= 11'(s.vtim.vsw)) ^ s.ctrl.ifs);
  endproperty
  a_fs_level: assert property (p_fs_level) else $error("frame sync off its lines");

  property p_rdy_line;
    pix_ready_out |-> s.hph == ldo_pkg::LDO_H_ACT && !s.hold_v && s.xcnt < s.htim.ppl;
  endproperty
  a_rdy_line: assert property (p_rdy_line) else $error("ready outside active region");

  c_fifo_full: cover property (s.qv == 2'b11);
  c_word_out: cover property (s.ctrl.en && !s.ctrl.act && $rose(panel_dot_clock_out));
  c_tft_px: cover property (s.ctrl.en && s.ctrl.act && s.bias);
  c_frame: cover property (s.ctrl.en && s.vcnt != 11'h000 ##1 s.vcnt == 11'h000);

endmodule : ldo_top

`default_nettype wire

// *** tb/ldo_panel_model.sv ***
// Purpose: panel side model that latches words at dot clock rises
// Assumes: panel pins sampled on the system clock, edges found by comparison
// Notes:   passive panels take every word, active panels only while valid
`timescale 1ns/10ps
`default_nettype none

module ldo_panel_model (
  input  wire logic        clk_in,
  input  wire logic        active_in,
  input  wire logic [15:0] data_in,
  input  wire logic        dot_in,
  input  wire logic        line_in,
  input  wire logic        frame_in,
  input  wire logic        bias_in,
  output var  logic [15:0] last_word_out,
  output var  int          words_out,
  output var  int          lines_out,
  output var  int          frames_out,
  output var  int          bias_edges_out
);
  logic dot_q;
  logic line_q;
  logic frame_q;
  logic bias_q;

  // Delayed copies; the dot clock is never used as a clock, avoiding races
  always_ff @(posedge clk_in) begin
    dot_q  <= dot_in;
    line_q <= line_in;
    frame_q <= frame_in;
    bias_q <= bias_in;
  end

  always_ff @(posedge clk_in) begin
    if (dot_in && !dot_q && (!active_in || bias_in)) begin
      last_word_out <= data_in;
      words_out     <= words_out + 1;
    end
    if (line_in && !line_q) begin
      lines_out <= lines_out + 1;
    end
    if (frame_in && !frame_q) begin
      frames_out <= frames_out + 1;
    end
    if (bias_in != bias_q) begin
      bias_edges_out <= bias_edges_out + 1;
    end
  end
endmodule : ldo_panel_model

`default_nettype wire

// *** tb/lcd_dither_output_stage_tb.sv ***
// Purpose: register and panel output checks of the dither output stage
// Assumes: pixels always offered; small porches, dot tick every fourth clock
// Notes:   mode is only changed while disabled
`timescale 1ns/10ps
`default_nettype none

module lcd_dither_output_stage_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic        rdy;
  logic [15:0] pix = 16'h0;
  logic        pix_ok = 1'b0;
  logic        act = 1'b0;
  logic [15:0] pd;
  logic        dot;
  logic        ls;
  logic        fs;
  logic        bi;
  logic [15:0] last;
  int          words;
  int          lines;
  int          bedges;
  int          frames;
  int          failures = 0;
  int          cmp_count = 0;
  logic [31:0] q;
  // Mode, pixel and expected pin word per case
  logic [8:0]  ctl_tab [10] = '{9'h013, 9'h003, 9'h001, 9'h001, 9'h001, 9'h009, 9'h005, 9'h005,
                                9'h011, 9'h1e1};
  logic [15:0] pix_tab [10] = '{16'ha5c3, 16'h09c5, 16'h000f, 16'h000e, 16'h0000, 16'h000f,
                                16'h0fff, 16'h0eee, 16'h001e, 16'h000f};
  logic [15:0] exp_tab [10] = '{16'ha5c3, 16'h9e6a, 16'h000f, 16'h000f, 16'h0000, 16'h00ff,
                                16'h00ff, 16'h00ff, 16'h000f, 16'h000f};
  logic [4:0]  ra [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h14};
  logic [31:0] rv [5] = '{32'h0, 32'h0404_0d40, 32'h0202_04f0, 32'h0000_0803, 32'h0};

  always #5 clk = ~clk;

  ldo_top dut (
    .ref_clk_in          (clk),
    .rst_n_in            (rst_n),
    .avs_address_in      (adr),
    .avs_read_in         (rd),
    .avs_write_in        (wr),
    .avs_writedata_in    (wdat),
    .avs_readdata_out    (rdat),
    .avs_waitrequest_out (wreq),
    .pix_data_in         (pix),
    .pix_valid_in        (pix_ok),
    .pix_ready_out       (rdy),
    .panel_data_out      (pd),
    .panel_dot_clock_out (dot),
    .line_sync_out       (ls),
    .frame_sync_out      (fs),
    .bias_toggle_out     (bi)
  );

  ldo_panel_model panel (
    .clk_in         (clk),
    .active_in      (act),
    .data_in        (pd),
    .dot_in         (dot),
    .line_in        (ls),
    .frame_in       (fs),
    .bias_in        (bi),
    .last_word_out  (last),
    .words_out      (words),
    .lines_out      (lines),
    .frames_out     (frames),
    .bias_edges_out (bedges)
  );

  // Verdict and end of run, also used when a wait runs out
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // One comparison of a value against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Avalon-MM transfer, request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    r  = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) begin
      failures++;
      tally_and_finish();
    end
  endtask : bus

  // Bounded wait for a number of further panel words
  task automatic wait_words(input int k);
    int n;
    int w0;
    n  = 0;
    w0 = words;
    while (words < w0 + k && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      tally_and_finish();
    end
  endtask : wait_words

  // Main sequence
  initial begin
    int l0;
    int b0;
    int f0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    chk({dot, ls, fs, bi, pd}, 32'h0);
    // Reset values and an unmapped address
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0, q);
      chk(q, rv[i]);
    end
    bus(1'b1, ldo_pkg::A_HTIM, 32'h0101_0408, q);
    bus(1'b1, ldo_pkg::A_VTIM, 32'h0000_0004, q);
    bus(1'b1, ldo_pkg::A_AUX, 32'h0000_0103, q);
    bus(1'b1, 5'h14, 32'hffff_ffff, q);
    bus(1'b0, ldo_pkg::A_HTIM, 32'h0, q);
    chk(q, 32'h0101_0408);
    // Inverted polarities while disabled give high inactive levels
    bus(1'b1, ldo_pkg::A_CTRL, 32'h0000_01e0, q);
    repeat (3) @(posedge clk);
    chk({dot, ls, fs, bi, pd}, {12'h0, 4'hf, 16'h0});
    pix_ok <= 1'b1;
    // Each table case of mode and pixel: pin word, unused pins, line sync and bias activity
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, ldo_pkg::A_CTRL, 32'h0, q);
      repeat (3) @(posedge clk);
      chk({15'h0, rdy, pd}, 32'h0);
      pix <= pix_tab[i];
      act <= ctl_tab[i][1];
      bus(1'b1, ldo_pkg::A_CTRL, {23'h0, ctl_tab[i]}, q);
      l0 = lines;
      b0 = bedges;
      f0 = frames;
      wait_words(12);
      chk({16'h0, last}, {16'h0, exp_tab[i]});
      chk({31'h0, frames != f0}, 32'h1);
      chk({31'h0, lines != l0}, 32'h1);
      chk({31'h0, bedges != b0}, 32'h1);
    end
    tally_and_finish();
  end
endmodule : lcd_dither_output_stage_tb

`default_nettype wire
